// ### dsadc_pkg.sv
package dsadc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ           = 25_000_000;
   localparam int SCK_MAX_HZ       = 3_000_000;
   // Half period rounds up so the shift clock never beats its limit
   localparam int SCK_HALF_CYC     = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
   localparam int RW_SETTLE_CYC    = 6;
   localparam int POWERUP_HOLD_CYC = 16;
   localparam int IZ_CYC           = 64;
   localparam int INT_UNIT_CYC     = 256;
   localparam int AZ_UNIT_CYC      = 256;
   // ==========================================================
   // Widths and reset values
   localparam int         CFG_W     = 8;
   localparam int         COUNT_W   = 17;
   localparam int         TMR_W     = 16;
   localparam int         HTMR_W    = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PH_AZ    = 2'b00,
      PH_IZ    = 2'b01,
      PH_INT   = 2'b10,
      PH_DEINT = 2'b11
   } dsadc_phase_e;
   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_SETTLE = 2'b01,
      H_HIGH   = 2'b10,
      H_LOW    = 2'b11
   } dsadc_hstate_e;
   // Duration of one phase from a nibble of the setting byte
   function automatic logic [TMR_W-1:0] dsadc_dur(input logic [3:0] nib,
                                                  input int unit);
      dsadc_dur = TMR_W'(({28'h0000000, nib} + 32'h00000001) * unit);
   endfunction
endpackage

// ### dsadc_if.sv
interface dsadc_if;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic rw;
   logic hold;
   logic eoc_out;
   logic eoc_oe;
   logic sdo_line;
   logic eoc_line;
   // ==========================================================
   // Wire levels; both lines pulled high when undriven
   assign sdo_line = sdo_oe ? sdo : 1'b1;
   assign eoc_line = eoc_oe ? eoc_out : 1'b1;
   modport dev (input sck, input sdi, input rw, input hold,
                output sdo, output sdo_oe, output eoc_out, output eoc_oe);
   modport host (output sck, output sdi, output rw, output hold,
                 input sdo_line, input eoc_line);
endinterface

// ### dsadc_sync.sv
module dsadc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   generate
      if (W < 1) begin : g_chk
         $error("dsadc_sync width must be positive");
      end
   endgenerate

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

// ### dsadc_dev.sv
module dsadc_dev #(
   parameter int COUNT_W      = dsadc_pkg::COUNT_W,
   parameter int INT_UNIT_CYC = dsadc_pkg::INT_UNIT_CYC,
   parameter int AZ_UNIT_CYC  = dsadc_pkg::AZ_UNIT_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   dsadc_if.dev                      lnk,
   input  wire logic                 cmp_zero_cross,
   input  wire logic                 cmp_negative,
   output logic                      offset_null_phase,
   output logic                      integrator_zero_phase,
   output logic                      integrate_phase,
   output logic                      reference_deintegrate_phase,
   output logic [COUNT_W+1:0]        result_word,
   output logic                      result_strobe
);
   localparam int RESULT_W = COUNT_W + 2;
   localparam int RCNT_W   = $clog2(RESULT_W);
   localparam int TMR_W    = dsadc_pkg::TMR_W;

   generate
      if (COUNT_W < 2 || COUNT_W > 30 || INT_UNIT_CYC < 1 || INT_UNIT_CYC > 4095
          || AZ_UNIT_CYC < 1 || AZ_UNIT_CYC > 4095) begin : g_chk
         $error("dsadc_dev parameters out of range");
      end
   endgenerate

   // ==========================================================
   // Link domain, rising edge: setting byte shift-in
   logic [7:0]          wsh_reg;
   logic [7:0]          wsh_next;
   logic [2:0]          wcnt_reg;
   logic [2:0]          wcnt_next;
   logic [7:0]          cfg_hold_reg;
   logic [7:0]          cfg_hold_next;
   logic                tog_reg;
   logic                tog_next;

   always_comb begin
      wsh_next      = wsh_reg;
      wcnt_next     = wcnt_reg;
      cfg_hold_next = cfg_hold_reg;
      tog_next      = tog_reg;
      if (!lnk.rw) begin
         wsh_next  = {wsh_reg[6:0], lnk.sdi};
         wcnt_next = wcnt_reg + 3'h1;
         if (wcnt_reg == 3'h7) begin
            // Byte held steady until the next full byte, toggle tells clk side
            cfg_hold_next = {wsh_reg[6:0], lnk.sdi};
            tog_next      = ~tog_reg;
         end
      end
   end

   always_ff @(posedge lnk.sck or negedge nrst) begin
      if (!nrst) begin
         wsh_reg      <= 8'h00;
         wcnt_reg     <= 3'h0;
         cfg_hold_reg <= dsadc_pkg::CFG_RESET;
         tog_reg      <= 1'b0;
      end else begin
         wsh_reg      <= wsh_next;
         wcnt_reg     <= wcnt_next;
         cfg_hold_reg <= cfg_hold_next;
         tog_reg      <= tog_next;
      end
   end

   // ==========================================================
   // Link domain, falling edge: result shift-out
   logic [RESULT_W-1:0] pub_reg;
   logic [RESULT_W-1:0] rsh_reg;
   logic [RESULT_W-1:0] rsh_next;
   logic [RCNT_W-1:0]   rcnt_reg;
   logic [RCNT_W-1:0]   rcnt_next;
   logic                sdo_reg;
   logic                sdo_next;

   always_comb begin
      rsh_next  = rsh_reg;
      rcnt_next = rcnt_reg;
      sdo_next  = sdo_reg;
      if (lnk.rw) begin
         // pub_reg is frozen by the clk side while read select is high
         if (rcnt_reg == '0) begin
            sdo_next = pub_reg[RESULT_W-1];
            rsh_next = {pub_reg[RESULT_W-2:0], 1'b0};
         end else begin
            sdo_next = rsh_reg[RESULT_W-1];
            rsh_next = {rsh_reg[RESULT_W-2:0], 1'b0};
         end
         rcnt_next = (rcnt_reg == RCNT_W'(RESULT_W - 1)) ? '0 : rcnt_reg + 1'b1;
      end
   end

   always_ff @(negedge lnk.sck or negedge nrst) begin
      if (!nrst) begin
         rsh_reg  <= '0;
         rcnt_reg <= '0;
         sdo_reg  <= 1'b0;
      end else begin
         rsh_reg  <= rsh_next;
         rcnt_reg <= rcnt_next;
         sdo_reg  <= sdo_next;
      end
   end

   // ==========================================================
   // Pin and setting-toggle synchronisers into the timebase domain
   logic [4:0] sync_q;
   logic       hold_s;
   logic       rw_s;
   logic       zc_s;
   logic       neg_s;
   logic       tog_s;

   dsadc_sync #(.W(5)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({lnk.hold, lnk.rw, cmp_zero_cross, cmp_negative, tog_reg}),
      .q    (sync_q)
   );
   assign {hold_s, rw_s, zc_s, neg_s, tog_s} = sync_q;

   // ==========================================================
   // Conversion sequencer
   dsadc_pkg::dsadc_phase_e ph_reg;
   dsadc_pkg::dsadc_phase_e ph_next;
   logic [TMR_W-1:0]    tmr_reg;
   logic [TMR_W-1:0]    tmr_next;
   logic [COUNT_W-1:0]  cnt_reg;
   logic [COUNT_W-1:0]  cnt_next;
   logic                pol_reg;
   logic                pol_next;
   logic [RESULT_W-1:0] res_next;
   logic [RESULT_W-1:0] pub_next;
   logic                tog_seen_reg;
   logic [7:0]          cfg_pend_reg;
   logic [7:0]          cfg_pend_next;
   logic [7:0]          cfg_act_reg;
   logic [7:0]          cfg_act_next;
   logic [TMR_W-1:0]    az_dur;
   logic [TMR_W-1:0]    int_dur;
   logic                strobe_next;
   logic                eoc_oe_reg;
   logic                sdo_oe_reg;

   assign az_dur  = dsadc_pkg::dsadc_dur(cfg_act_reg[3:0], AZ_UNIT_CYC);
   assign int_dur = dsadc_pkg::dsadc_dur(cfg_act_reg[7:4], INT_UNIT_CYC);

   always_comb begin
      ph_next       = ph_reg;
      tmr_next      = tmr_reg + 1'b1;
      cnt_next      = cnt_reg;
      pol_next      = pol_reg;
      res_next      = result_word;
      strobe_next   = 1'b0;
      cfg_pend_next = (tog_s != tog_seen_reg) ? cfg_hold_reg : cfg_pend_reg;
      cfg_act_next  = (ph_reg == dsadc_pkg::PH_AZ) ? cfg_pend_reg : cfg_act_reg;
      pub_next      = rw_s ? pub_reg : result_word;
      case (ph_reg)
         dsadc_pkg::PH_AZ: begin
            if (tmr_reg >= az_dur - 1'b1) begin
               ph_next  = dsadc_pkg::PH_IZ;
               tmr_next = '0;
            end
         end
         dsadc_pkg::PH_IZ: begin
            if (tmr_reg == TMR_W'(dsadc_pkg::IZ_CYC - 1)) begin
               ph_next  = dsadc_pkg::PH_INT;
               tmr_next = '0;
            end
         end
         dsadc_pkg::PH_INT: begin
            if (tmr_reg >= int_dur - 1'b1) begin
               ph_next  = dsadc_pkg::PH_DEINT;
               tmr_next = '0;
               cnt_next = '0;
               pol_next = neg_s;
            end
         end
         default: begin
            cnt_next = cnt_reg + 1'b1;
            tmr_next = '0;
            // Saturated count without a crossing marks overrange
            if (zc_s || &cnt_reg) begin
               res_next    = {&cnt_reg & ~zc_s, pol_reg, cnt_reg};
               strobe_next = 1'b1;
               ph_next     = dsadc_pkg::PH_AZ;
            end
         end
      endcase
      if (hold_s) begin
         ph_next  = dsadc_pkg::PH_AZ;
         tmr_next = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_reg                      <= dsadc_pkg::PH_AZ;
         tmr_reg                     <= '0;
         cnt_reg                     <= '0;
         pol_reg                     <= 1'b0;
         result_word                 <= '0;
         pub_reg                     <= '0;
         result_strobe               <= 1'b0;
         tog_seen_reg                <= 1'b0;
         cfg_pend_reg                <= dsadc_pkg::CFG_RESET;
         cfg_act_reg                 <= dsadc_pkg::CFG_RESET;
         eoc_oe_reg                  <= 1'b1;
         sdo_oe_reg                  <= 1'b0;
         offset_null_phase           <= 1'b1;
         integrator_zero_phase       <= 1'b0;
         integrate_phase             <= 1'b0;
         reference_deintegrate_phase <= 1'b0;
      end else begin
         ph_reg                      <= ph_next;
         tmr_reg                     <= tmr_next;
         cnt_reg                     <= cnt_next;
         pol_reg                     <= pol_next;
         result_word                 <= res_next;
         pub_reg                     <= pub_next;
         result_strobe               <= strobe_next;
         tog_seen_reg                <= tog_s;
         cfg_pend_reg                <= cfg_pend_next;
         cfg_act_reg                 <= cfg_act_next;
         eoc_oe_reg                  <= (ph_next == dsadc_pkg::PH_AZ);
         sdo_oe_reg                  <= rw_s;
         offset_null_phase           <= (ph_next == dsadc_pkg::PH_AZ);
         integrator_zero_phase       <= (ph_next == dsadc_pkg::PH_IZ);
         integrate_phase             <= (ph_next == dsadc_pkg::PH_INT);
         reference_deintegrate_phase <= (ph_next == dsadc_pkg::PH_DEINT);
      end
   end

   // ==========================================================
   // Pin drive; end flag is open drain so it only ever pulls low
   assign lnk.sdo     = sdo_reg;
   assign lnk.sdo_oe  = sdo_oe_reg;
   assign lnk.eoc_out = 1'b0;
   assign lnk.eoc_oe  = eoc_oe_reg;
endmodule

// ### dsadc_host.sv
module dsadc_host #(
   parameter int RESULT_W = dsadc_pkg::COUNT_W + 2
) (
   input  wire logic                clk,
   input  wire logic                nrst,
   dsadc_if.host                    lnk,
   input  wire logic                cfg_wr,
   input  wire logic [7:0]          cfg_byte,
   input  wire logic                rd_req,
   input  wire logic                conv_hold,
   output logic [RESULT_W-1:0]      rd_data,
   output logic                     rd_valid,
   output logic                     busy,
   output logic                     data_ready,
   output logic                     eoc_level
);
   localparam int HTMR_W = dsadc_pkg::HTMR_W;
   localparam int BCNT_W = $clog2(RESULT_W + 1);

   generate
      if (RESULT_W < 9 || dsadc_pkg::SCK_HALF_CYC < 3) begin : g_chk
         $error("dsadc_host parameters out of range");
      end
   endgenerate

   // ==========================================================
   // Line synchronisers
   logic sdo_s;
   logic eoc_s;

   dsadc_sync #(.W(2)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({lnk.sdo_line, lnk.eoc_line}),
      .q    ({sdo_s, eoc_s})
   );

   // ==========================================================
   // Serial frame engine; shift clock from a divider, no second domain
   dsadc_pkg::dsadc_hstate_e st_reg;
   dsadc_pkg::dsadc_hstate_e st_next;
   logic [HTMR_W-1:0]   tmr_reg;
   logic [HTMR_W-1:0]   tmr_next;
   logic [BCNT_W-1:0]   bcnt_reg;
   logic [BCNT_W-1:0]   bcnt_next;
   logic [RESULT_W-1:0] sh_reg;
   logic [RESULT_W-1:0] sh_next;
   logic                rd_reg;
   logic                rd_next;
   logic                sck_reg;
   logic                sdi_reg;
   logic                rw_reg;
   logic                hold_reg;
   logic                hold_next;
   logic                eoc_d_reg;
   logic                rd_valid_next;
   logic [RESULT_W-1:0] rd_data_next;
   logic [4:0]          pwr_reg;
   logic [4:0]          pwr_next;

   always_comb begin
      st_next       = st_reg;
      tmr_next      = tmr_reg + 1'b1;
      bcnt_next     = bcnt_reg;
      sh_next       = sh_reg;
      rd_next       = rd_reg;
      rd_valid_next = 1'b0;
      rd_data_next  = rd_data;
      case (st_reg)
         dsadc_pkg::H_IDLE: begin
            tmr_next = '0;
            if (cfg_wr) begin
               st_next = dsadc_pkg::H_SETTLE;
               rd_next = 1'b0;
               sh_next = {cfg_byte, {(RESULT_W - 8){1'b0}}};
            end else if (rd_req) begin
               st_next = dsadc_pkg::H_SETTLE;
               rd_next = 1'b1;
               sh_next = '0;
            end
         end
         dsadc_pkg::H_SETTLE: begin
            // Lets the far end see the select level before any edge
            if (tmr_reg == HTMR_W'(dsadc_pkg::RW_SETTLE_CYC - 1)) begin
               st_next   = dsadc_pkg::H_HIGH;
               tmr_next  = '0;
               bcnt_next = '0;
            end
         end
         dsadc_pkg::H_HIGH: begin
            if (tmr_reg == HTMR_W'(dsadc_pkg::SCK_HALF_CYC - 1)) begin
               st_next  = dsadc_pkg::H_LOW;
               tmr_next = '0;
               if (!rd_reg) begin
                  sh_next = {sh_reg[RESULT_W-2:0], 1'b0};
               end
            end
         end
         default: begin
            if (tmr_reg == HTMR_W'(dsadc_pkg::SCK_HALF_CYC - 1)) begin
               tmr_next  = '0;
               bcnt_next = bcnt_reg + 1'b1;
               if (rd_reg) begin
                  sh_next = {sh_reg[RESULT_W-2:0], sdo_s};
               end
               st_next = dsadc_pkg::H_HIGH;
               if (bcnt_reg == BCNT_W'((rd_reg ? RESULT_W : 8) - 1)) begin
                  st_next = dsadc_pkg::H_IDLE;
                  if (rd_reg) begin
                     rd_data_next  = {sh_reg[RESULT_W-2:0], sdo_s};
                     rd_valid_next = 1'b1;
                  end
               end
            end
         end
      endcase
      // Hold rises only while the end flag is low, falls at any time after the power-up hold
      pwr_next  = (pwr_reg == 5'(dsadc_pkg::POWERUP_HOLD_CYC)) ? pwr_reg : pwr_reg + 1'b1;
      hold_next = conv_hold ? (hold_reg | ~eoc_s) : 1'b0;
      if (pwr_reg != 5'(dsadc_pkg::POWERUP_HOLD_CYC)) begin
         hold_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg     <= dsadc_pkg::H_IDLE;
         tmr_reg    <= '0;
         bcnt_reg   <= '0;
         sh_reg     <= '0;
         rd_reg     <= 1'b0;
         sck_reg    <= 1'b0;
         sdi_reg    <= 1'b0;
         rw_reg     <= 1'b0;
         hold_reg   <= 1'b1;
         pwr_reg    <= 5'h00;
         // Matches the synchroniser's reset level, so no false fall follows reset
         eoc_d_reg  <= 1'b0;
         rd_data    <= '0;
         rd_valid   <= 1'b0;
         busy       <= 1'b0;
         data_ready <= 1'b0;
         eoc_level  <= 1'b1;
      end else begin
         st_reg     <= st_next;
         tmr_reg    <= tmr_next;
         bcnt_reg   <= bcnt_next;
         sh_reg     <= sh_next;
         rd_reg     <= rd_next;
         sck_reg    <= (st_next == dsadc_pkg::H_HIGH);
         // Parked low in reads so it never moves under a high shift clock
         sdi_reg    <= rd_next ? 1'b0 : sh_next[RESULT_W-1];
         rw_reg     <= (st_next != dsadc_pkg::H_IDLE) && rd_next;
         hold_reg   <= hold_next;
         pwr_reg    <= pwr_next;
         eoc_d_reg  <= eoc_s;
         rd_data    <= rd_data_next;
         rd_valid   <= rd_valid_next;
         busy       <= (st_next != dsadc_pkg::H_IDLE);
         data_ready <= eoc_d_reg & ~eoc_s;
         eoc_level  <= eoc_s;
      end
   end

   assign lnk.sck  = sck_reg;
   assign lnk.sdi  = sdi_reg;
   assign lnk.rw   = rw_reg;
   assign lnk.hold = hold_reg;
endmodule

// ### dsadc_sva.sv
module dsadc_sva (
   input wire logic clk,
   input wire logic lclk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic rw,
   input wire logic hold,
   input wire logic eoc_out,
   input wire logic eoc_oe
);
   // ==========================================================
   // Host side, host clock
   sck_high_a: assert property (
      @(posedge clk) disable iff (!nrst) $rose(sck) |-> sck[*5] ##1 !sck)
      else $error("shift clock high time wrong");
   sdi_setup_a: assert property (
      @(posedge clk) disable iff (!nrst) $changed(sdi) |-> !sck)
      else $error("setting bit moved while shift clock high");
   rw_stable_a: assert property (
      @(posedge clk) disable iff (!nrst) sck |-> $stable(rw))
      else $error("read select moved inside a shift pulse");
   // ==========================================================
   // Device side, link clock
   sdo_enable_a: assert property (
      @(posedge lclk) disable iff (!nrst) (!rw)[*5] |-> !sdo_oe)
      else $error("serial output driven while writing");
   sdo_fall_a: assert property (
      @(posedge lclk) disable iff (!nrst) sdo_oe && $stable(sdo_oe) && $changed(sdo) |-> !sck)
      else $error("result bit moved while shift clock high");
   hold_eoc_a: assert property (
      @(posedge lclk) disable iff (!nrst) $rose(hold) |-> ##[0:6] eoc_oe)
      else $error("end flag not low after hold");
   hold_halt_a: assert property (
      @(posedge lclk) disable iff (!nrst) hold[*6] |-> eoc_oe)
      else $error("conversion ran during hold");
   eoc_drain_a: assert property (
      @(posedge lclk) disable iff (!nrst) eoc_oe |-> !eoc_out)
      else $error("end flag driven high");
   null_min_a: assert property (
      @(posedge lclk) disable iff (!nrst) $rose(eoc_oe) |-> eoc_oe[*4])
      else $error("end flag low too short");
   null_exit_a: assert property (
      @(posedge lclk) disable iff (!nrst) $fell(eoc_oe) |-> !eoc_oe[*8])
      else $error("end flag back low during zero phase");
endmodule

// ### tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int UNIT = 4;
   localparam int RW   = dsadc_pkg::COUNT_W + 2;
   logic          clk, lclk, nrst, cmp_zero_cross, cmp_negative;
   logic          cfg_wr, rd_req, conv_hold, rd_valid, busy, data_ready, eoc_level;
   logic          offset_null_phase, integrator_zero_phase, integrate_phase;
   logic          reference_deintegrate_phase, result_strobe, held;
   logic [7:0]    cfg_byte, rnd, cfg_cur, sh;
   logic [3:0]    ph, ph_prev;
   logic [RW-1:0] result_word, rd_data, last_exp, rsh;
   logic [RW-1:0] exp_q[$];
   int            bad_count, n_tests, d_win, ph_cnt, n_rdy;
   dsadc_if lnk();
   dsadc_dev #(.INT_UNIT_CYC(UNIT), .AZ_UNIT_CYC(UNIT)) dsadc_dev_i (
      .clk(lclk), .nrst(nrst), .lnk(lnk), .cmp_zero_cross(cmp_zero_cross),
      .cmp_negative(cmp_negative), .offset_null_phase(offset_null_phase),
      .integrator_zero_phase(integrator_zero_phase), .integrate_phase(integrate_phase),
      .reference_deintegrate_phase(reference_deintegrate_phase),
      .result_word(result_word), .result_strobe(result_strobe));
   dsadc_host dsadc_host_i (
      .clk(clk), .nrst(nrst), .lnk(lnk), .cfg_wr(cfg_wr), .cfg_byte(cfg_byte),
      .rd_req(rd_req), .conv_hold(conv_hold), .rd_data(rd_data), .rd_valid(rd_valid),
      .busy(busy), .data_ready(data_ready), .eoc_level(eoc_level));
   dsadc_sva dsadc_sva_i (
      .clk(clk), .lclk(lclk), .nrst(nrst), .sck(lnk.sck), .sdi(lnk.sdi), .sdo(lnk.sdo),
      .sdo_oe(lnk.sdo_oe), .rw(lnk.rw), .hold(lnk.hold), .eoc_out(lnk.eoc_out),
      .eoc_oe(lnk.eoc_oe));
   // ==========================================================
   // Clocks; link clock offset so the two never line up
   always #20 clk = ~clk;
   initial begin
      lclk = 1'b0;
      #7;
      forever #15 lclk = ~lclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Crossing time is only known to a few cycles of sync lag
   task automatic chk_res(input logic [RW-1:0] seen, input logic [RW-1:0] exp);
      check(32'(seen[RW-1:RW-2]), 32'(exp[RW-1:RW-2]));
      check(32'((seen[RW-3:0] - exp[RW-3:0]) <= 4), 32'h1);
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Comparator stand-in and expectation notes
   always begin
      @(posedge integrator_zero_phase);
      #1 cmp_negative = rnd[7];
      @(posedge reference_deintegrate_phase);
      d_win = 8 + int'(rnd[4:0]);
      rnd = lfsr(rnd);
      repeat (d_win) @(posedge lclk);
      #1 cmp_zero_cross = 1'b1;
      exp_q.push_back({1'b0, cmp_negative, dsadc_pkg::COUNT_W'(d_win)});
      @(negedge reference_deintegrate_phase);
      #1 cmp_zero_cross = 1'b0;
   end
   always begin
      @(posedge lclk);
      #2;
      if (result_strobe === 1'b1) begin
         check(32'(exp_q.size() > 0), 32'h1);
         last_exp = exp_q.pop_front();
         chk_res(result_word, last_exp);
         repeat (2) @(posedge lclk);
         check(32'(lnk.eoc_oe), 32'h1);
      end
   end
   // ==========================================================
   // Wire watchers and phase sequence
   always @(posedge lnk.sck) begin
      if (!lnk.rw) sh <= {sh[6:0], lnk.sdi};
   end
   // Result bit is valid just after each falling shift edge
   always @(negedge lnk.sck) begin
      #1;
      if (lnk.rw) rsh <= {rsh[RW-2:0], lnk.sdo_line};
   end
   always @(posedge clk) begin
      #2;
      if (data_ready === 1'b1) n_rdy++;
   end
   assign ph = {reference_deintegrate_phase, integrate_phase, integrator_zero_phase,
                offset_null_phase};
   always @(posedge lclk) begin
      if (!nrst) begin
         ph_prev <= 4'h1;
         ph_cnt <= 0;
         held <= 1'b1;
      end else if (ph == ph_prev) begin
         ph_cnt <= ph_cnt + 1;
         if (lnk.hold) held <= 1'b1;
      end else begin
         check(32'(ph), 32'({ph_prev[2:0], ph_prev[3]}));
         if (ph_prev == 4'h2) check(ph_cnt, dsadc_pkg::IZ_CYC);
         if (ph_prev == 4'h4) check(ph_cnt, (cfg_cur[7:4] + 1) * UNIT);
         if (ph_prev == 4'h1 && !held) check(ph_cnt, (cfg_cur[3:0] + 1) * UNIT);
         ph_prev <= ph;
         ph_cnt <= 1;
         held <= lnk.hold;
      end
   end
   // ==========================================================
   // Host user side
   task automatic host_op(input logic rd, input logic [7:0] b);
      int k;
      k = 0;
      @(posedge clk);
      #1 cfg_wr = !rd;
      rd_req = rd;
      cfg_byte = b;
      if (!rd) cfg_cur = b;
      @(posedge clk);
      #1 cfg_wr = 1'b0;
      rd_req = 1'b0;
      do begin
         @(posedge clk);
         #1 k++;
      end while ((rd ? rd_valid : !busy) !== 1'b1 && k < 400);
      if (k >= 400) check(32'h0, 32'h1);
   endtask
   task automatic wait_res;
      int k;
      k = 0;
      do begin
         @(posedge lclk);
         #2 k++;
      end while (result_strobe !== 1'b1 && k < 3000);
      if (k >= 3000) check(32'h0, 32'h1);
   endtask
   initial begin
      {clk, nrst, cmp_zero_cross, cmp_negative, cfg_wr, rd_req} = 6'h00;
      {conv_hold, cfg_byte, cfg_cur, rnd, last_exp} = {1'b1, 8'h00, 8'h00, 8'h47, {RW{1'b0}}};
      repeat (16) @(posedge clk);
      #1 nrst = 1'b1;
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 5000 && lnk.hold !== 1'b1; k++) @(posedge clk);
         rnd = lfsr(rnd);
         // Null of at least 9 units (36 link clock cycles), so hold raised after a result lands inside it
         host_op(1'b0, rnd | 8'h08);
         check(32'(sh), 32'(cfg_cur));
         host_op(1'b1, 8'h00);
         chk_res(rd_data, last_exp);
         chk_res(rsh, last_exp);
         repeat (8) @(posedge clk);
         check(32'(lnk.sdo_line), 32'h1);
         check(32'(eoc_level), 32'h0);
         #1 conv_hold = 1'b0;
         wait_res();
         wait_res();
         @(posedge clk);
         #1 conv_hold = 1'b1;
      end
      repeat (8) @(posedge clk);
      check(n_rdy, 8);
      wrap_up();
   end
   // Hang guard, far beyond the expected run length
   initial begin
      #400000;
      bad_count++;
      wrap_up();
   end
endmodule
